/* File: acc_pkg.sv */
// Overview of operation
// - Each conversion yields 12-bit result, read-only
// - Justify zero: high=D11..4, low=D3..0 upper
// - Justify one: high=D11..8 low nibble, low=D7..0
// - Enable low clears both result registers
// - Enable low switches converter off
// - Start rising resets converter, clears busy
// - Start falling after rise begins conversion, busy
// - Busy clears when result registers updated
// - Busy flag read-only, writes ignored
// - Source 000 or 100 converts external channel
// - Channel codes 000..111 map to inputs 0..7
// - Source 001/010/011 selects supply, half, quarter
// - Internal source disconnects external channel input
// - Clock select divides system clock by 2^code
// - Pin function bit claims pin as analog
// - Analog pin disables its pull-high resistor
// - Unimplemented control bits read zero
// - Completion raises converter interrupt request flag
package acc_pkg;
  // Register word offsets (byte addresses)
  localparam logic [4:0] ACC_OFS_RES_LOW = 5'h00;
  localparam logic [4:0] ACC_OFS_RES_HIGH = 5'h04;
  localparam logic [4:0] ACC_OFS_START_CH = 5'h08;
  localparam logic [4:0] ACC_OFS_SRC_CLK = 5'h0C;
  localparam logic [4:0] ACC_OFS_REF = 5'h10;
  localparam logic [4:0] ACC_OFS_PIN_SEL = 5'h14;
  // Control field positions
  localparam int ACC_BIT_START = 7;
  localparam int ACC_BIT_BUSY = 6;
  localparam int ACC_BIT_EN = 5;
  localparam int ACC_BIT_JUST = 4;
  // Reset values
  localparam logic [7:0] ACC_RST_START_CH = 8'h00;
  localparam logic [7:0] ACC_RST_SRC_CLK = 8'h00;
  localparam logic [7:0] ACC_RST_REF = 8'h00;
  localparam logic [7:0] ACC_RST_PIN_SEL = 8'hFF;
  // Writable masks (unimplemented bits read zero)
  localparam logic [7:0] ACC_MASK_START_CH = 8'hB7;
  localparam logic [7:0] ACC_MASK_SRC_CLK = 8'hE7;
  // Conversion length in converter clocks
  localparam logic [4:0] ACC_CONV_CLKS = 5'h10;
  // Input source codes
  typedef enum logic [2:0] {
    ACC_SRC_EXT = 3'b000,
    ACC_SRC_VDD = 3'b001,
    ACC_SRC_VDD2 = 3'b010,
    ACC_SRC_VDD4 = 3'b011,
    ACC_SRC_EXT2 = 3'b100
  } acc_src_e;
  typedef enum logic [1:0] {
    ACC_ST_IDLE = 2'b00,
    ACC_ST_ARMED = 2'b01,
    ACC_ST_CONV = 2'b10
  } acc_state_e;
endpackage : acc_pkg

/* File: acc_top.sv */
`timescale 1ns/1ns
module acc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [11:0] sample_data_i,
  output logic [7:0] external_analog_inputs_o,
  output logic [1:0] internal_ratio_o,
  output logic internal_sel_o,
  output logic conv_power_o,
  output logic sample_strobe_o,
  output logic [7:0] pin_analog_o,
  output logic [7:0] pullhigh_disable_o,
  output logic [7:0] ref_ctrl_o,
  output logic conv_irq_flag_o
);
  import acc_pkg::*;

  logic [7:0] start_ch_r, start_ch_nxt;
  logic [7:0] src_clk_r, src_clk_nxt;
  logic [7:0] ref_r, ref_nxt;
  logic [7:0] pin_sel_r, pin_sel_nxt;
  logic [11:0] result_r, result_nxt;
  logic busy_r, busy_nxt;
  logic irq_r, irq_nxt;
  logic samp_r, samp_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic [6:0] div_r, div_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  acc_state_e state_r, state_nxt;
  logic wr_en, rd_en, start_new, tick, en;
  logic [2:0] src;

  // Divider terminal: count reaches 2^code - 1
  function automatic logic div_done(input logic [6:0] cnt, input logic [2:0] code);
    logic [7:0] lim;
    lim = (8'h01 << code) - 8'h01;
    div_done = ({1'b0, cnt} >= lim);
  endfunction : div_done

  // Result formatting per justify bit
  function automatic logic [15:0] fmt(input logic [11:0] d, input logic j);
    fmt = j ? {4'h0, d} : {d, 4'h0};
  endfunction : fmt

  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r && wb_sel_i[0];
  assign rd_en = wb_cyc_i && wb_stb_i && !ack_r;
  assign en = start_ch_r[ACC_BIT_EN];
  assign src = src_clk_r[7:5];
  assign start_new = wr_en && (wb_adr_i == ACC_OFS_START_CH);

  // Register writes
  always_comb begin
    start_ch_nxt = start_ch_r;
    src_clk_nxt = src_clk_r;
    ref_nxt = ref_r;
    pin_sel_nxt = pin_sel_r;
    if (wr_en) begin
      unique case (wb_adr_i)
        ACC_OFS_START_CH: start_ch_nxt = wb_dat_i[7:0] & ACC_MASK_START_CH;
        ACC_OFS_SRC_CLK: src_clk_nxt = wb_dat_i[7:0] & ACC_MASK_SRC_CLK;
        ACC_OFS_REF: ref_nxt = wb_dat_i[7:0];
        ACC_OFS_PIN_SEL: pin_sel_nxt = wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_ch_r <= ACC_RST_START_CH;
      src_clk_r <= ACC_RST_SRC_CLK;
      ref_r <= ACC_RST_REF;
      pin_sel_r <= ACC_RST_PIN_SEL;
    end else begin
      start_ch_r <= start_ch_nxt;
      src_clk_r <= src_clk_nxt;
      ref_r <= ref_nxt;
      pin_sel_r <= pin_sel_nxt;
    end
  end

  // Bus answer: ack one cycle after request
  always_comb begin
    logic [15:0] f;
    f = fmt(result_r, start_ch_r[ACC_BIT_JUST]);
    ack_nxt = rd_en;
    rdat_nxt = 32'h0000_0000;
    if (rd_en) begin
      unique case (wb_adr_i)
        ACC_OFS_RES_LOW: rdat_nxt = {24'h000000, f[7:0]};
        ACC_OFS_RES_HIGH: rdat_nxt = {24'h000000, f[15:8]};
        ACC_OFS_START_CH: rdat_nxt = {24'h000000, start_ch_r[7], busy_r, start_ch_r[5:0]};
        ACC_OFS_SRC_CLK: rdat_nxt = {24'h000000, src_clk_r};
        ACC_OFS_REF: rdat_nxt = {24'h000000, ref_r};
        ACC_OFS_PIN_SEL: rdat_nxt = {24'h000000, pin_sel_r};
        default: rdat_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // Conversion sequencer
  always_comb begin
    state_nxt = state_r;
    busy_nxt = busy_r;
    result_nxt = result_r;
    div_nxt = div_r;
    cnt_nxt = cnt_r;
    irq_nxt = 1'b0;
    samp_nxt = 1'b0;
    tick = div_done(div_r, src_clk_r[2:0]);
    if (state_r == ACC_ST_CONV) begin
      div_nxt = tick ? 7'h00 : div_r + 7'h01;
    end
    if (!en) begin
      state_nxt = ACC_ST_IDLE;
      busy_nxt = 1'b0;
      result_nxt = 12'h000;
    end else if (start_new && wb_dat_i[ACC_BIT_START] && !start_ch_r[ACC_BIT_START]) begin
      state_nxt = ACC_ST_ARMED;
      busy_nxt = 1'b0;
    end else if (start_new && !wb_dat_i[ACC_BIT_START] && start_ch_r[ACC_BIT_START]
                 && state_r == ACC_ST_ARMED) begin
      state_nxt = ACC_ST_CONV;
      busy_nxt = 1'b1;
      div_nxt = 7'h00;
      cnt_nxt = 5'h00;
    end else if (state_r == ACC_ST_CONV && tick) begin
      if (cnt_r == ACC_CONV_CLKS - 5'h01) begin
        state_nxt = ACC_ST_IDLE;
        busy_nxt = 1'b0;
        result_nxt = sample_data_i;
        irq_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 5'h01;
        if (cnt_r == 5'h00) begin
          samp_nxt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ACC_ST_IDLE;
      busy_r <= 1'b0;
      result_r <= 12'h000;
      div_r <= 7'h00;
      cnt_r <= 5'h00;
      irq_r <= 1'b0;
      samp_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r <= busy_nxt;
      result_r <= result_nxt;
      div_r <= div_nxt;
      cnt_r <= cnt_nxt;
      irq_r <= irq_nxt;
      samp_r <= samp_nxt;
    end
  end

  // Input routing and pin control
  always_comb begin
    logic ext;
    ext = (src == ACC_SRC_EXT) || (src == ACC_SRC_EXT2);
    external_analog_inputs_o = 8'h00;
    if (ext && en) begin
      external_analog_inputs_o = 8'h01 << start_ch_r[2:0];
    end
    internal_sel_o = !ext && en;
    internal_ratio_o = src[1:0] - 2'h1;
  end

  assign pin_analog_o = pin_sel_r;
  assign pullhigh_disable_o = pin_sel_r;
  assign conv_power_o = en;
  assign sample_strobe_o = samp_r;
  assign ref_ctrl_o = ref_r;
  assign conv_irq_flag_o = irq_r;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
endmodule : acc_top

/* File: acc_top_checker.sv */
`timescale 1ns/1ns
module acc_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [7:0] external_analog_inputs_o,
  input wire logic internal_sel_o,
  input wire logic conv_power_o,
  input wire logic sample_strobe_o,
  input wire logic [7:0] pin_analog_o,
  input wire logic [7:0] pullhigh_disable_o,
  input wire logic conv_irq_flag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus request taken by the slave
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  property p_ack; s_take |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ackd; wb_ack_o |=> !wb_ack_o; endproperty
  a_ackd: assert property (p_ackd) else $error("ack long");
  property p_rdz; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("upper data");
  property p_one; $onehot0(external_analog_inputs_o); endproperty
  a_one: assert property (p_one) else $error("two channels");
  property p_int; internal_sel_o |-> external_analog_inputs_o == 8'h00; endproperty
  a_int: assert property (p_int) else $error("ext on");
  property p_off; !conv_power_o |-> external_analog_inputs_o == 8'h00; endproperty
  a_off: assert property (p_off) else $error("ext when off");
  property p_pull; pullhigh_disable_o == pin_analog_o; endproperty
  a_pull: assert property (p_pull) else $error("pull-high");
  property p_irq; conv_irq_flag_o |-> conv_power_o ##1 !conv_irq_flag_o; endproperty
  a_irq: assert property (p_irq) else $error("irq pulse");
  property p_strb; sample_strobe_o |=> !sample_strobe_o; endproperty
  a_strb: assert property (p_strb) else $error("strobe long");
endmodule : acc_chk
bind acc_top acc_chk acc_chk_i (.*);

/* File: acc_top_tb_top.sv */
`timescale 1ns/1ns
module acc_top_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] dat = 32'h0;
  logic [11:0] smp = 12'h000;
  logic [31:0] rdat;
  logic ack, cpw, isel, irq, sst;
  logic [7:0] ext, pin, phd, rfc, rd;
  logic [1:0] rat;
  logic [15:0] f;
  logic [11:0] s;
  logic [3:0] sel = 4'hF;
  int irq_seen = 0;
  int strb_seen = 0;
  int ib;
  int sb;
  int num_errors = 0;
  int checks_done = 0;
  integer seed = 32'h215b018c;
  acc_top acc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sample_data_i(smp), .external_analog_inputs_o(ext),
    .internal_ratio_o(rat), .internal_sel_o(isel), .conv_power_o(cpw),
    .sample_strobe_o(sst), .pin_analog_o(pin), .pullhigh_disable_o(phd),
    .ref_ctrl_o(rfc), .conv_irq_flag_o(irq));
  // Clock
  initial forever #4 clk_i = ~clk_i;
  // Count completion and sample pulses
  always @(posedge clk_i) begin
    if (irq === 1'b1) irq_seen++;
    if (sst === 1'b1) strb_seen++;
  end
  // Compare and count
  task chk(input logic [15:0] sn, input logic [15:0] ex);
    checks_done++;
    if (sn !== ex) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, sn, ex);
    end
  endtask : chk
  // Classic single cycle
  task bus(input logic [4:0] a, input logic [7:0] d, input logic w);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat[7:0];
    {cyc, stb} <= 2'b00;
  endtask : bus
  task rc(input logic [4:0] a, input logic [7:0] ex);
    bus(a, 8'h00, 1'b0);
    chk(rd, ex);
  endtask : rc
  // Expected result layout
  function logic [15:0] fmt(input logic [11:0] d, input logic j);
    return j ? {4'h0, d} : {d, 4'h0};
  endfunction : fmt
  task conclude;
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  // Watchdog
  initial begin
    #800000;
    num_errors++;
    conclude();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(5'h08, 8'h00);
    rc(5'h0C, 8'h00);
    rc(5'h14, 8'hFF);
    rc(5'h18, 8'h00);
    bus(5'h10, 8'h5A, 1'b1);
    rc(5'h10, 8'h5A);
    chk(rfc, 8'h5A);
    sel <= 4'hE;
    bus(5'h10, 8'hA5, 1'b1);
    sel <= 4'hF;
    rc(5'h10, 8'h5A);
    bus(5'h08, 8'hFF, 1'b1);
    rc(5'h08, 8'hB7);
    bus(5'h0C, 8'hFF, 1'b1);
    rc(5'h0C, 8'hE7);
    for (int k = 0; k < 40; k++) begin
      bus(5'h0C, {k[5:3], 5'h00}, 1'b1);
      bus(5'h08, {5'h04, k[2:0]}, 1'b1);
      chk(ext, k[4:3] == 2'b00 ? 8'h01 << k[2:0] : 8'h00);
      if (k[4:3] != 2'b00) chk({isel, rat}, {1'b1, k[4:3] - 2'd1});
    end
    for (int n = 0; n < 10; n++) begin
      s = 12'($random(seed));
      smp <= s;
      bus(5'h14, s[7:0], 1'b1);
      chk({pin, phd}, {2{s[7:0]}});
      bus(5'h0C, {5'h00, n == 9 ? 3'h7 : 3'(n % 3)}, 1'b1);
      bus(5'h08, {3'b101, n[0], 4'h0}, 1'b1);
      rc(5'h08, {3'b101, n[0], 4'h0});
      ib = irq_seen;
      sb = strb_seen;
      bus(5'h08, {3'b001, n[0], 4'h0}, 1'b1);
      rc(5'h08, {3'b011, n[0], 4'h0});
      for (int w = 0; w < 1000 && rd[6]; w++) bus(5'h08, 8'h00, 1'b0);
      chk(rd, {3'b001, n[0], 4'h0});
      chk(16'(irq_seen - ib), 16'h0001);
      chk(16'(strb_seen - sb), 16'h0001);
      f = fmt(s, n[0]);
      rc(5'h04, f[15:8]);
      rc(5'h00, f[7:0]);
    end
    bus(5'h08, 8'h00, 1'b1);
    rc(5'h04, 8'h00);
    rc(5'h00, 8'h00);
    conclude();
  end
endmodule : acc_top_tb_top
